// ---- verilog/dxbs_pkg.sv ----
// dxbs_pkg: constants for the external bus sequencer
// assumes: one 100 MHz core clock, synchronous active-high reset
package dxbs_pkg;
   localparam int          ADDR_W       = 12;
   localparam int          DATA_W       = 16;
   localparam int          PORT_W       = 3;
   localparam int          SYNC_STAGES  = 2;
   localparam int          RESET_MIN_CYC = 5;
   localparam logic [11:0] ADDR_ZERO    = 12'h000;
   localparam logic [15:0] DATA_ZERO    = 16'h0000;
   localparam logic [11:0] PORT_HIGH    = 12'hff8;
   localparam logic [11:0] PC_STEP      = 12'h001;
   // operation codes
   localparam logic [2:0]  OP_NONE      = 3'h0;
   localparam logic [2:0]  OP_TABLE_READ_OP      = 3'h1;
   localparam logic [2:0]  OP_TABLE_WRITE_OP      = 3'h2;
   localparam logic [2:0]  OP_IN        = 3'h3;
   localparam logic [2:0]  OP_OUT       = 3'h4;
   // bus cycle states
   typedef enum logic [5:0] {
      DXBS_RST   = 6'h01,
      DXBS_FETCH = 6'h02,
      DXBS_DUMMY = 6'h04,
      DXBS_DATA  = 6'h08,
      DXBS_PORT  = 6'h10,
      DXBS_WAIT  = 6'h20
   } dxbs_state_t;
endpackage : dxbs_pkg

// ---- verilog/dxbs_sync.sv ----
// dxbs_sync: two-flop synchroniser for the reset pin
// assumes: input is asynchronous to core_clk
`timescale 1ns/10ps
module dxbs_sync (
   // clock
   input  wire logic core_clk,
   // pin and synchronised level
   input  wire logic asyncIn,
   output logic      syncOut
);
   logic stage1;
   always_ff @(posedge core_clk) begin
      stage1  <= asyncIn;
      syncOut <= stage1;
   end
endmodule : dxbs_sync

// ---- verilog/dxbs_sequencer.sv ----
// dxbs_sequencer: program memory and port bus cycle sequencer
// assumes: core issues one op at a time on opValid when opReady is high
`timescale 1ns/10ps
module dxbs_sequencer (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        reset_in_n,
   // core side
   input  wire logic        opValid,
   input  wire logic [2:0]  opKind,
   input  wire logic [11:0] opAddr,
   input  wire logic [2:0]  opPort,
   input  wire logic [15:0] opWData,
   output logic             opReady,
   output logic             rdValid,
   output logic [15:0]      rdData,
   output logic [15:0]      instrWord,
   output logic             instrValid,
   // external bus
   output logic [11:0]      address_outputs,
   output logic             program_memory_strobe_n,
   output logic             io_read_strobe_n,
   output logic             write_strobe_n,
   input  wire logic [15:0] dataIn,
   output logic [15:0]      dataOut,
   output logic             dataOe
);
   logic                 pinResetN;
   logic                 inReset;
   logic [11:0]          pc;
   logic [2:0]           curOp;
   logic [11:0]          curAddr;
   logic [2:0]           curPort;
   logic [15:0]          curData;
   logic [15:0]          dataSample;
   logic                 rdPending;
   dxbs_pkg::dxbs_state_t state;

   function automatic logic [11:0] port_addr(input logic [2:0] p);
      port_addr = dxbs_pkg::PORT_HIGH | {9'h000, p};
   endfunction : port_addr

   // both reset edges pass two flops
   dxbs_sync u_sync (
      .core_clk (core_clk),
      .asyncIn  (reset_in_n),
      .syncOut  (pinResetN)
   );

   assign inReset = rst | ~pinResetN;

   // read data sampled off the pin into flops
   always_ff @(posedge core_clk) begin
      dataSample <= dataIn;
   end

   // sequence of bus cycles
   always_ff @(posedge core_clk) begin
      if (inReset) begin
         state   <= dxbs_pkg::DXBS_RST;
         pc      <= dxbs_pkg::ADDR_ZERO;
         curOp   <= dxbs_pkg::OP_NONE;
         curAddr <= dxbs_pkg::ADDR_ZERO;
         curPort <= 3'h0;
         curData <= dxbs_pkg::DATA_ZERO;
      end else begin
         case (state)
            dxbs_pkg::DXBS_RST: begin
               state <= dxbs_pkg::DXBS_WAIT;
            end
            dxbs_pkg::DXBS_WAIT: begin
               if (opValid) begin
                  curOp   <= opKind;
                  curAddr <= opAddr;
                  curPort <= opPort;
                  curData <= opWData;
                  state   <= dxbs_pkg::DXBS_FETCH;
               end
            end
            dxbs_pkg::DXBS_FETCH: begin
               pc <= pc + dxbs_pkg::PC_STEP;
               if (curOp == dxbs_pkg::OP_TABLE_READ_OP || curOp == dxbs_pkg::OP_TABLE_WRITE_OP)
                  state <= dxbs_pkg::DXBS_DUMMY;
               else if (curOp == dxbs_pkg::OP_IN || curOp == dxbs_pkg::OP_OUT)
                  state <= dxbs_pkg::DXBS_PORT;
               else
                  state <= dxbs_pkg::DXBS_WAIT;
            end
            dxbs_pkg::DXBS_DUMMY: begin
               state <= dxbs_pkg::DXBS_DATA;
            end
            dxbs_pkg::DXBS_DATA, dxbs_pkg::DXBS_PORT: begin
               curOp <= dxbs_pkg::OP_NONE;
               state <= dxbs_pkg::DXBS_WAIT;
            end
            default: begin
               state <= dxbs_pkg::DXBS_RST;
            end
         endcase
      end
   end

   // bus pins, registered; strobes mutually exclusive
   always_ff @(posedge core_clk) begin
      if (inReset) begin
         program_memory_strobe_n <= 1'b1;
         io_read_strobe_n        <= 1'b1;
         write_strobe_n          <= 1'b1;
         dataOe                  <= 1'b0;
         dataOut                 <= dxbs_pkg::DATA_ZERO;
         address_outputs         <= dxbs_pkg::ADDR_ZERO;
      end else begin
         program_memory_strobe_n <= 1'b1;
         io_read_strobe_n        <= 1'b1;
         write_strobe_n          <= 1'b1;
         dataOe                  <= 1'b0;
         case (state)
            dxbs_pkg::DXBS_WAIT: begin
               if (opValid) begin
                  address_outputs         <= pc;
                  program_memory_strobe_n <= 1'b0;
               end
            end
            dxbs_pkg::DXBS_FETCH: begin
               if (curOp == dxbs_pkg::OP_IN) begin
                  address_outputs  <= port_addr(curPort);
                  io_read_strobe_n <= 1'b0;
               end else if (curOp == dxbs_pkg::OP_OUT) begin
                  address_outputs <= port_addr(curPort);
                  write_strobe_n  <= 1'b0;
                  dataOe          <= 1'b1;
                  dataOut         <= curData;
               end else if (curOp != dxbs_pkg::OP_NONE) begin
                  address_outputs         <= pc + dxbs_pkg::PC_STEP;
                  program_memory_strobe_n <= 1'b0;
               end
            end
            dxbs_pkg::DXBS_DUMMY: begin
               address_outputs <= curAddr;
               if (curOp == dxbs_pkg::OP_TABLE_READ_OP) begin
                  program_memory_strobe_n <= 1'b0;
               end else begin
                  write_strobe_n <= 1'b0;
                  dataOe         <= 1'b1;
                  dataOut        <= curData;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // core side results; read data taken at strobe end
   always_ff @(posedge core_clk) begin
      if (inReset) begin
         opReady    <= 1'b0;
         rdValid    <= 1'b0;
         rdPending  <= 1'b0;
         rdData     <= dxbs_pkg::DATA_ZERO;
         instrWord  <= dxbs_pkg::DATA_ZERO;
         instrValid <= 1'b0;
      end else begin
         opReady    <= (state == dxbs_pkg::DXBS_WAIT) && !opValid;
         rdValid    <= rdPending;
         instrValid <= 1'b0;
         // flag the read cycle; its word lands in dataSample at the strobe end
         rdPending  <= (state == dxbs_pkg::DXBS_DATA && curOp == dxbs_pkg::OP_TABLE_READ_OP) ||
                       (state == dxbs_pkg::DXBS_PORT && curOp == dxbs_pkg::OP_IN);
         if (state == dxbs_pkg::DXBS_FETCH) begin
            instrWord  <= dataIn;
            instrValid <= 1'b1;
         end
         if (rdPending) begin
            rdData <= dataSample;
         end
      end
   end

   // checks
   sequence table_read_op_start_s;
      state == dxbs_pkg::DXBS_FETCH && curOp == dxbs_pkg::OP_TABLE_READ_OP;
   endsequence

   strobe_excl_a: assert property (@(posedge core_clk) disable iff (rst)
      $onehot0({~program_memory_strobe_n, ~io_read_strobe_n, ~write_strobe_n}))
      else $error("more than one strobe active");

   reset_idle_a: assert property (@(posedge core_clk)
      $past(inReset) |-> program_memory_strobe_n && io_read_strobe_n && write_strobe_n
      && !dataOe && address_outputs == dxbs_pkg::ADDR_ZERO)
      else $error("bus not idle after reset");

   pc_clear_a: assert property (@(posedge core_clk)
      $past(inReset) |-> pc == dxbs_pkg::ADDR_ZERO)
      else $error("pc not cleared");

   restart_one_a: assert property (@(posedge core_clk) disable iff (inReset)
      state == dxbs_pkg::DXBS_RST |=> state == dxbs_pkg::DXBS_WAIT)
      else $error("restart not one cycle");

   sync_delay_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(reset_in_n) ##1 !reset_in_n |=> inReset)
      else $error("reset pin not seen after two flops");

   table_read_op_seq_a: assert property (@(posedge core_clk) disable iff (inReset)
      table_read_op_start_s |=> !program_memory_strobe_n ##1
      (!program_memory_strobe_n && address_outputs == curAddr))
      else $error("table read sequence wrong");

   table_write_op_data_a: assert property (@(posedge core_clk) disable iff (inReset)
      state == dxbs_pkg::DXBS_DUMMY && curOp == dxbs_pkg::OP_TABLE_WRITE_OP |=>
      !write_strobe_n && dataOe && dataOut == curData)
      else $error("table write data missing");

   table_read_op_data_a: assert property (@(posedge core_clk) disable iff (inReset)
      state == dxbs_pkg::DXBS_DATA && curOp == dxbs_pkg::OP_TABLE_READ_OP |=>
      ##1 (rdValid && rdData == $past(dataIn, 2)))
      else $error("table read word not returned");

   in_port_a: assert property (@(posedge core_clk) disable iff (inReset)
      state == dxbs_pkg::DXBS_FETCH && curOp == dxbs_pkg::OP_IN |=>
      !io_read_strobe_n && !dataOe && address_outputs == port_addr(curPort))
      else $error("port read cycle wrong");

   out_port_a: assert property (@(posedge core_clk) disable iff (inReset)
      state == dxbs_pkg::DXBS_FETCH && curOp == dxbs_pkg::OP_OUT |=>
      !write_strobe_n && dataOe && address_outputs == port_addr(curPort))
      else $error("port write cycle wrong");

   oe_write_a: assert property (@(posedge core_clk) disable iff (rst)
      dataOe |-> !write_strobe_n)
      else $error("data driven without write strobe");
endmodule : dxbs_sequencer

// ---- testbench/dxbs_ext_dev.sv ----
// dxbs_ext_dev: program memory and peripheral port model on the far bus
// assumes: active-low strobes from dxbs_sequencer, one core clock
`timescale 1ns/10ps
module dxbs_ext_dev (
   // clock
   input  wire logic        core_clk,
   // bus from the sequencer
   input  wire logic [11:0] address_outputs,
   input  wire logic        program_memory_strobe_n,
   input  wire logic        io_read_strobe_n,
   input  wire logic        write_strobe_n,
   input  wire logic [15:0] dataOut,
   input  wire logic        dataOe,
   // read data and last write seen
   output logic      [15:0] dataIn,
   output logic      [27:0] lastWr
);
   logic [15:0] held = 16'h0000;
   // read word only while a read strobe is low, else a moving pattern
   always_comb begin
      if (!program_memory_strobe_n)
         dataIn = {4'h5, address_outputs};
      else if (!io_read_strobe_n)
         dataIn = 16'hc3c0 ^ {4'h0, address_outputs};
      else
         dataIn = ~held;
   end
   always @(posedge core_clk) held <= dataIn;
   // capture address and word while the write strobe is low
   always @(negedge core_clk) begin
      if (!write_strobe_n)
         lastWr <= {address_outputs, dataOe ? dataOut : 16'hxxxx};
   end
endmodule : dxbs_ext_dev

// ---- testbench/dxbs_sequencer_bench.sv ----
// dxbs_sequencer_bench: self-checking bench for the bus sequencer
// assumes: far bus modelled by dxbs_ext_dev, assertions live in the design
`timescale 1ns/10ps
module dxbs_sequencer_bench;
   logic        core_clk, rst, reset_in_n, opValid, opReady, rdValid;
   logic        instrValid, dataOe;
   logic [2:0]  opKind, opPort, stb;
   logic [11:0] opAddr, address_outputs;
   logic [15:0] opWData, rdData, instrWord, dataIn, dataOut;
   logic        program_memory_strobe_n, io_read_strobe_n, write_strobe_n;
   logic [27:0] lastWr;
   logic [15:0] seen[$];
   int          bad_count = 0;
   int          checked = 0;
   int          pcModel = 0;
   assign stb = {program_memory_strobe_n, io_read_strobe_n, write_strobe_n};
   dxbs_sequencer dut (.core_clk, .rst, .reset_in_n, .opValid, .opKind, .opAddr,
      .opPort, .opWData, .opReady, .rdValid, .rdData, .instrWord, .instrValid,
      .address_outputs, .program_memory_strobe_n, .io_read_strobe_n,
      .write_strobe_n, .dataIn, .dataOut, .dataOe);
   dxbs_ext_dev far (.core_clk, .address_outputs, .program_memory_strobe_n,
      .io_read_strobe_n, .write_strobe_n, .dataOut, .dataOe, .dataIn, .lastWr);
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("counts: %0d compared, %0d wrong", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick
   // bus cycle log and strobe exclusion
   always @(negedge core_clk) begin
      check({15'h0, $countones(stb) >= 2}, 16'h0001);
      if (stb != 3'b111)
         seen.push_back({1'b0, stb, address_outputs});
   end
   task automatic do_op(input logic [2:0] k);
      logic [11:0] a, pa, pf;
      logic [2:0]  p;
      logic [15:0] w, got, ins, ex[$];
      int          n;
      a = 12'($urandom);
      p = 3'($urandom);
      w = 16'($urandom);
      pa = dxbs_pkg::PORT_HIGH | {9'h000, p};
      got = 16'hxxxx;
      ins = 16'hxxxx;
      n = 0;
      while (opReady !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      opKind = k;
      opAddr = a;
      opPort = p;
      opWData = w;
      opValid = 1;
      n = 0;
      do begin
         tick(1);
         n++;
      end while (program_memory_strobe_n !== 1'b0 && n < 20);
      opValid = 0;
      repeat (8) begin
         if (rdValid === 1'b1)
            got = rdData;
         if (instrValid === 1'b1)
            ins = instrWord;
         tick(1);
      end
      pf = 12'(pcModel);
      pcModel++;
      ex.push_back({4'h3, pf});
      if (k == 3'h1 || k == 3'h2) ex.push_back({4'h3, pf + 12'h001});
      if (k == 3'h1) ex.push_back({4'h3, a});
      if (k == 3'h2) ex.push_back({4'h6, a});
      if (k == 3'h3) ex.push_back({4'h5, pa});
      if (k == 3'h4) ex.push_back({4'h6, pa});
      check(16'(seen.size()), 16'(ex.size()));
      foreach (ex[i]) check(seen[i], ex[i]);
      if (k == 3'h1) check(got, {4'h5, a});
      if (k == 3'h3) check(got, 16'hc3c0 ^ {4'h0, pa});
      check(ins, {4'h5, pf});
      if (k == 3'h2) check(lastWr[15:0], w);
      if (k == 3'h2) check({4'h0, lastWr[27:16]}, {4'h0, a});
      if (k == 3'h4) check(lastWr[15:0], w);
      if (k == 3'h4) check({4'h0, lastWr[27:16]}, {4'h0, pa});
      seen.delete();
   endtask : do_op
   // pull the reset pin in the middle of a table write
   task automatic pin_reset;
      opKind = 3'h2;
      opAddr = 12'($urandom);
      opValid = 1;
      tick(2);
      reset_in_n = 0;
      opValid = 0;
      tick(5); // pin held five cycles
      check({13'h0, stb, dataOe}, 16'h000e);
      check({4'h0, address_outputs}, 16'h0000);
      reset_in_n = 1;
      seen.delete(); // interrupted write is not trusted
      pcModel = 0;
   endtask : pin_reset
   initial begin
      void'($urandom(91));
      rst = 1;
      reset_in_n = 0;
      opValid = 0;
      opKind = 3'h0;
      opAddr = 12'h000;
      opPort = 3'h0;
      opWData = 16'h0000;
      tick(3);
      rst = 0;
      tick(2);
      reset_in_n = 1;
      seen.delete();
      for (int r = 0; r < 3; r++) begin
         for (int k = 0; k < 5; k++) do_op(3'(k));
         $display("test op round %0d done", r);
      end
      pin_reset();
      do_op(3'h1);
      do_op(3'h3);
      $display("test reset mid write done");
      complete_run();
   end
   initial begin
      #50us;
      bad_count++;
      complete_run();
   end
endmodule : dxbs_sequencer_bench
